// ===== fsrt_pkg.sv
// Package for the flash program-store sequencer and read timing block.
// Assumes an 8-bit register port and a 20 MHz core clock.

package fsrt_pkg;

  // ********************************
  // Register offsets
  // ********************************
  localparam logic [7:0] PROGRAM_STORE_CONTROL_ADDR = 8'h8f;
  localparam logic [7:0] FLASH_SCALE_REGISTER_ADDR = 8'hb6;
  localparam logic [7:0] ONESHOT_PERIOD_ADDR = 8'haf;
  localparam logic [7:0] IRQ_STATUS_ADDR = 8'he0;
  localparam logic [7:0] IRQ_CLEAR_ADDR = 8'he1;
  localparam logic [7:0] IRQ_ENABLE_ADDR = 8'he2;

  // ********************************
  // Field positions
  // ********************************
  localparam int STORE_WRITE_ENABLE_BIT = 0;
  localparam int PAGE_ERASE_ENABLE_BIT = 1;
  localparam int READ_TIME_SELECT_BIT = 4;
  localparam int IRQ_PROG_BIT = 0;
  localparam int IRQ_ERASE_BIT = 1;
  localparam int IRQ_ERROR_BIT = 2;
  localparam int IRQ_W = 3;

  // ********************************
  // Reset values
  // ********************************
  localparam logic [1:0] PROGRAM_STORE_CONTROL_RST = 2'h0;
  localparam logic READ_TIME_SELECT_RST = 1'b0;
  localparam logic [3:0] SCALE_LOW_RST = 4'h3;
  localparam logic [IRQ_W-1:0] IRQ_ENABLE_RST = 3'h0;

  // ********************************
  // Timing
  // ********************************
  localparam int CLK_PERIOD_NS = 50;
  localparam int ONESHOT_DEFAULT_NS = 80;
  localparam int ONESHOT_RAW_CYC = ONESHOT_DEFAULT_NS / CLK_PERIOD_NS;
  localparam int ONESHOT_CYC = (ONESHOT_RAW_CYC < 1) ? 1 : ONESHOT_RAW_CYC;
  localparam logic [3:0] ONESHOT_RST = ONESHOT_CYC[3:0];
  localparam logic [1:0] STROBE_FAST_CYC = 2'h1;
  localparam logic [1:0] STROBE_SLOW_CYC = 2'h2;

  // ********************************
  // Types
  // ********************************
  typedef enum logic {
    FSRT_RD_IDLE = 1'b0,
    FSRT_RD_ACTIVE = 1'b1
  } fsrt_rd_state_t;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] data;
  } fsrt_move_t;

  typedef struct packed {
    logic prog;
    logic erase;
    logic [15:0] addr;
    logic [7:0] data;
  } fsrt_flash_cmd_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } fsrt_reg_req_t;

endpackage

// ===== fsrt_flash_seq.sv
// Flash program-store sequencer with read strobe timing and interrupts.
// Assumes a core that issues moves, reads and fetches as one-cycle pulses.
`timescale 1ns/1ps
`default_nettype none

// Operation
// - Both enables set: move write erases the page of the address.
// - Erase ignores the data byte of the move write.
// - Store write enable alone: move write programs one byte.
// - Upper six control bits read zero, writes to them do nothing.
// - Read timing resets to the slow clock safe one-cycle strobe.
// - Every data read and fetch raises a read strobe to flash, except one arriving mid-width.
// - Strobe is one cycle, or two when read time select is set and the one-shot period is two or more.
// - Flash active only while strobe high, low power otherwise.
// - Strobe held beyond one width only when a new read arrives in its last cycle.
// - Between threshold and limit the clock period sets strobe width.
// - Below threshold a one-shot ends the strobe, default reliable width.
// - Supply monitor off on write or erase: error reset, skip it.
module fsrt_flash_seq (
  input wire logic core_clk_i,                 // Core clock
  input wire logic rst_n_i,                    // Sync reset, low
  input wire fsrt_pkg::fsrt_reg_req_t reg_req_i, // Register access
  output logic [7:0] reg_rdata_o,              // Read data, next cycle
  input wire logic move_wr_i,                  // Move write to flash
  input wire fsrt_pkg::fsrt_move_t move_i,     // Move address and data
  input wire logic flash_read_i,               // Data read or fetch
  input wire logic supply_mon_en_i,            // Supply monitor on
  input wire logic supply_rst_en_i,            // Monitor reset source on
  output fsrt_pkg::fsrt_flash_cmd_t flash_cmd_o, // Program or erase
  output logic flash_rd_strobe_o,              // Read strobe to array
  output logic flash_active_o,                 // Array out of low power
  output logic flash_err_reset_o,              // Error device reset
  output logic irq_o                           // Level interrupt
);
  import fsrt_pkg::*;

  // ********************************
  // Helpers
  // ********************************
  function automatic logic [1:0] strobe_len(input logic slow,
                                            input logic [3:0] os);
    logic [1:0] clk_len;
    logic [3:0] os_len;
    clk_len = slow ? STROBE_SLOW_CYC : STROBE_FAST_CYC;
    os_len = (os == 4'h0) ? 4'h1 : os;
    if (os_len < {2'h0, clk_len}) begin
      strobe_len = os_len[1:0];
    end else begin
      strobe_len = clk_len;
    end
  endfunction

  function automatic logic wr_hit(input fsrt_reg_req_t req,
                                  input logic [7:0] addr);
    wr_hit = req.wr && (req.addr == addr);
  endfunction

  // ********************************
  // Register state
  // ********************************
  logic page_erase_enable_q;
  logic store_write_enable_q;
  logic read_time_select_q;
  logic [3:0] scale_low_q;
  logic [3:0] oneshot_q;
  logic [IRQ_W-1:0] irq_status_q;
  logic [IRQ_W-1:0] irq_enable_q;
  logic [7:0] rdata_q;
  logic wr_ctl;
  logic wr_scale;
  logic wr_os;
  logic wr_clr;
  logic wr_en;

  assign wr_ctl = wr_hit(reg_req_i, PROGRAM_STORE_CONTROL_ADDR);
  assign wr_scale = wr_hit(reg_req_i, FLASH_SCALE_REGISTER_ADDR);
  assign wr_os = wr_hit(reg_req_i, ONESHOT_PERIOD_ADDR);
  assign wr_clr = wr_hit(reg_req_i, IRQ_CLEAR_ADDR);
  assign wr_en = wr_hit(reg_req_i, IRQ_ENABLE_ADDR);

  // ********************************
  // Register write port
  // ********************************

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      page_erase_enable_q <= PROGRAM_STORE_CONTROL_RST[PAGE_ERASE_ENABLE_BIT];
      store_write_enable_q <=
        PROGRAM_STORE_CONTROL_RST[STORE_WRITE_ENABLE_BIT];
    end else if (wr_ctl) begin
      page_erase_enable_q <= reg_req_i.wdata[PAGE_ERASE_ENABLE_BIT];
      store_write_enable_q <= reg_req_i.wdata[STORE_WRITE_ENABLE_BIT];
    end
  end

  // ********************************
  // Timing registers
  // ********************************

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      read_time_select_q <= READ_TIME_SELECT_RST;
      scale_low_q <= SCALE_LOW_RST;
    end else if (wr_scale) begin
      read_time_select_q <= reg_req_i.wdata[READ_TIME_SELECT_BIT];
      scale_low_q <= reg_req_i.wdata[3:0];
    end
  end

  // one-shot period defaults to reliable width
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      oneshot_q <= ONESHOT_RST;
    end else if (wr_os) begin
      oneshot_q <= reg_req_i.wdata[3:0];
    end
  end

  // Enable mask, same layout as status
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      irq_enable_q <= IRQ_ENABLE_RST;
    end else if (wr_en) begin
      irq_enable_q <= reg_req_i.wdata[IRQ_W-1:0];
    end
  end

  // ********************************
  // Register read port
  // ********************************
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      rdata_q <= 8'h00;
    end else if (reg_req_i.rd) begin
      unique case (reg_req_i.addr)
        PROGRAM_STORE_CONTROL_ADDR:
          rdata_q <= {6'h00, page_erase_enable_q, store_write_enable_q};
        FLASH_SCALE_REGISTER_ADDR:
          rdata_q <= {3'h0, read_time_select_q, scale_low_q};
        ONESHOT_PERIOD_ADDR: rdata_q <= {4'h0, oneshot_q};
        IRQ_STATUS_ADDR: rdata_q <= {5'h00, irq_status_q};
        IRQ_ENABLE_ADDR: rdata_q <= {5'h00, irq_enable_q};
        // Clear register is write-only
        default: rdata_q <= 8'h00;
      endcase
    end else begin
      rdata_q <= 8'h00;
    end
  end

  assign reg_rdata_o = rdata_q;

  // ********************************
  // Move write sequencing
  // ********************************
  logic supply_ok;
  logic move_hit;
  logic do_erase;
  logic do_prog;
  logic do_error;
  fsrt_flash_cmd_t cmd_q;
  logic err_q;

  // Both supply inputs must be on
  assign supply_ok = supply_mon_en_i && supply_rst_en_i;
  assign move_hit = move_wr_i && store_write_enable_q;
  assign do_error = move_hit && !supply_ok;
  assign do_erase = move_hit && supply_ok && page_erase_enable_q;
  // write enable alone programs a byte
  assign do_prog = move_hit && supply_ok && !page_erase_enable_q;

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      cmd_q <= '0;
    end else begin
      cmd_q.prog <= do_prog;
      cmd_q.erase <= do_erase;
      // Erase keeps the full address
      if (do_prog || do_erase) begin
        cmd_q.addr <= move_i.addr;
      end
      if (do_prog) begin
        cmd_q.data <= move_i.data;
      end else if (do_erase) begin
        cmd_q.data <= 8'h00;
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      err_q <= 1'b0;
    end else begin
      err_q <= do_error;
    end
  end

  assign flash_cmd_o = cmd_q;
  assign flash_err_reset_o = err_q;

  // ********************************
  // Read strobe timing
  // ********************************
  fsrt_rd_state_t rd_state_q;
  logic [1:0] rd_cnt_q;
  logic strobe_q;
  logic active_q;
  logic rd_take;
  logic rd_last;

  assign rd_last = (rd_state_q == FSRT_RD_ACTIVE) && (rd_cnt_q == 2'h1);
  // Requests in mid-width are refused
  assign rd_take = flash_read_i
    && ((rd_state_q == FSRT_RD_IDLE) || rd_last);

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      rd_state_q <= FSRT_RD_IDLE;
      rd_cnt_q <= 2'h0;
    end else if (rd_take) begin
      // each read or fetch starts a strobe
      rd_state_q <= FSRT_RD_ACTIVE;
      // clock period limits at mid speeds
      // earlier of one-shot and clock strobe
      rd_cnt_q <= strobe_len(read_time_select_q, oneshot_q);
    end else begin
      unique case (rd_state_q)
        FSRT_RD_IDLE: rd_cnt_q <= 2'h0;
        FSRT_RD_ACTIVE: begin
          // strobe drops at end of width
          if (rd_cnt_q == 2'h1) begin
            rd_state_q <= FSRT_RD_IDLE;
            rd_cnt_q <= 2'h0;
          end else begin
            rd_cnt_q <= rd_cnt_q - 2'h1;
          end
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      strobe_q <= 1'b0;
      active_q <= 1'b0;
    end else begin
      // Back-to-back reads keep it high
      strobe_q <= rd_take || (rd_state_q == FSRT_RD_ACTIVE && !rd_last);
      active_q <= rd_take || (rd_state_q == FSRT_RD_ACTIVE && !rd_last);
    end
  end

  assign flash_rd_strobe_o = strobe_q;
  assign flash_active_o = active_q;

  // ********************************
  // Interrupts
  // ********************************
  logic [IRQ_W-1:0] irq_set;
  logic irq_q;

  always_comb begin
    irq_set = '0;
    irq_set[IRQ_PROG_BIT] = do_prog;
    irq_set[IRQ_ERASE_BIT] = do_erase;
    irq_set[IRQ_ERROR_BIT] = do_error;
  end

  // Set wins over a same-cycle clear
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      irq_status_q <= '0;
    end else if (wr_clr) begin
      irq_status_q <= (irq_status_q & ~reg_req_i.wdata[IRQ_W-1:0]) | irq_set;
    end else begin
      irq_status_q <= irq_status_q | irq_set;
    end
  end

  // Level output, one cycle behind status
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(irq_status_q & irq_enable_q);
    end
  end

  assign irq_o = irq_q;

endmodule

`default_nettype wire

// ===== fsrt_flash_seq_monitor.sv
// Port checker for the flash sequencer.
// Assumes it is bound onto fsrt_flash_seq.
`timescale 1ns/1ps
`default_nettype none
module fsrt_flash_seq_monitor (
  input wire logic core_clk_i, // Clock
  input wire logic rst_n_i, // Reset
  input wire fsrt_pkg::fsrt_reg_req_t reg_req_i, // Reg access
  input wire logic [7:0] reg_rdata_o, // Read data
  input wire logic move_wr_i, // Move write
  input wire fsrt_pkg::fsrt_move_t move_i, // Move
  input wire logic flash_read_i, // Read
  input wire logic supply_mon_en_i, // Monitor
  input wire logic supply_rst_en_i, // Source
  input wire fsrt_pkg::fsrt_flash_cmd_t flash_cmd_o, // Command
  input wire logic flash_rd_strobe_o, // Strobe
  input wire logic flash_active_o, // Active
  input wire logic flash_err_reset_o, // Error
  input wire logic irq_o // Interrupt
);
  import fsrt_pkg::*;
  logic [1:0] ctl_q;
  logic sel_q;
  logic [3:0] os_q;
  logic ok_w;
  logic lng_w;
  assign ok_w = supply_mon_en_i && supply_rst_en_i;
  assign lng_w = sel_q && (os_q > 4'h1);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  // ****
  // Shadow of written settings
  // ****
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      ctl_q <= PROGRAM_STORE_CONTROL_RST;
      sel_q <= READ_TIME_SELECT_RST;
      os_q <= ONESHOT_RST;
    end else if (reg_req_i.wr) begin
      case (reg_req_i.addr)
        PROGRAM_STORE_CONTROL_ADDR: ctl_q <= reg_req_i.wdata[1:0];
        FLASH_SCALE_REGISTER_ADDR: sel_q <= reg_req_i.wdata[4];
        ONESHOT_PERIOD_ADDR: os_q <= reg_req_i.wdata[3:0];
        default: ;
      endcase
    end
  end
  // ****
  // Properties
  // ****
  sequence s_req;
    !flash_rd_strobe_o && flash_read_i;
  endsequence
  sequence s_mv;
    move_wr_i && ctl_q[0] && ok_w;
  endsequence
  property p_active;
    flash_active_o == flash_rd_strobe_o;
  endproperty
  a_active: assert property (p_active)
    else $error("active differs from strobe");
  property p_on;
    s_req |=> flash_rd_strobe_o;
  endproperty
  a_on: assert property (p_on)
    else $error("no strobe for read");
  property p_short;
    s_req ##0 !lng_w ##1 !flash_read_i |=> !flash_rd_strobe_o;
  endproperty
  a_short: assert property (p_short)
    else $error("short strobe too long");
  property p_long;
    s_req ##0 lng_w |=> flash_rd_strobe_o [*2];
  endproperty
  a_long: assert property (p_long)
    else $error("long strobe too short");
  property p_prog;
    s_mv ##0 !ctl_q[1] |=> flash_cmd_o.prog && !flash_cmd_o.erase
      && flash_cmd_o.addr == $past(move_i.addr)
      && flash_cmd_o.data == $past(move_i.data);
  endproperty
  a_prog: assert property (p_prog)
    else $error("program command wrong");
  property p_erase;
    s_mv ##0 ctl_q[1] |=> flash_cmd_o.erase && !flash_cmd_o.prog
      && flash_cmd_o.addr == $past(move_i.addr)
      && flash_cmd_o.data == 8'h00;
  endproperty
  a_erase: assert property (p_erase)
    else $error("erase command wrong");
  property p_err;
    move_wr_i && ctl_q[0] && !ok_w |=> flash_err_reset_o
      && !flash_cmd_o.prog && !flash_cmd_o.erase;
  endproperty
  a_err: assert property (p_err)
    else $error("supply error not handled");
  property p_off;
    move_wr_i && !ctl_q[0] |=> !flash_cmd_o.prog && !flash_cmd_o.erase;
  endproperty
  a_off: assert property (p_off)
    else $error("move acted while disabled");
endmodule
bind fsrt_flash_seq fsrt_flash_seq_monitor u_mon (.*);
`default_nettype wire

// ===== fsrt_core_model.sv
// Core model issuing fetches and move writes.
// Assumes the core clock of the sequencer.
`timescale 1ns/1ps
`default_nettype none
module fsrt_core_model (
  input wire logic core_clk_i, // Clock
  output logic flash_read_o, // Fetch pulse
  output logic move_wr_o, // Move pulse
  output fsrt_pkg::fsrt_move_t move_o // Move fields
);
  import fsrt_pkg::*;
  initial begin
    flash_read_o = 1'b0;
    move_wr_o = 1'b0;
    move_o = '0;
  end
  task automatic fetch();
    @(posedge core_clk_i);
    flash_read_o <= 1'b1;
    @(posedge core_clk_i);
    flash_read_o <= 1'b0;
  endtask
  task automatic move(input logic [15:0] a, input logic [7:0] d);
    @(posedge core_clk_i);
    move_wr_o <= 1'b1;
    move_o <= {a, d};
    @(posedge core_clk_i);
    move_wr_o <= 1'b0;
    move_o <= ~{a, d};
  endtask
endmodule
`default_nettype wire

// ===== fsrt_flash_seq_tb_top.sv
// Testbench for the flash sequencer.
// Assumes the port checker is bound in.
`timescale 1ns/1ps
`default_nettype none
module fsrt_flash_seq_tb_top;
  import fsrt_pkg::*;
  logic core_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic mon = 1'b1;
  logic src = 1'b1;
  fsrt_reg_req_t req = '0;
  fsrt_move_t mv;
  fsrt_flash_cmd_t cmd;
  logic [7:0] rdata;
  logic mw, frd, stb, act, err, irq;
  int n_fail = 0;
  int num_checks = 0;
  int cyc = 0;
  logic [7:0] os_t [4] = '{8'h02, 8'h02, 8'h01, 8'h00};
  logic [7:0] sl_t [4] = '{8'h10, 8'h00, 8'h10, 8'h10};
  logic [7:0] ln_t [4] = '{8'h02, 8'h01, 8'h01, 8'h01};
  always #25 core_clk_i = ~core_clk_i;
  fsrt_core_model u_core (.core_clk_i(core_clk_i), .flash_read_o(frd),
    .move_wr_o(mw), .move_o(mv));
  fsrt_flash_seq u_dut (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
    .reg_req_i(req), .reg_rdata_o(rdata), .move_wr_i(mw), .move_i(mv),
    .flash_read_i(frd), .supply_mon_en_i(mon), .supply_rst_en_i(src),
    .flash_cmd_o(cmd), .flash_rd_strobe_o(stb), .flash_active_o(act),
    .flash_err_reset_o(err), .irq_o(irq));
  task automatic chk(input string w, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      n_fail++;
      $display("BAD %s exp %h got %h", w, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk_i);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge core_clk_i);
    req.wr <= 1'b0;
  endtask
  task automatic rd(input string w, input logic [7:0] a, input logic [7:0] e);
    @(posedge core_clk_i);
    req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge core_clk_i);
    req.rd <= 1'b0;
    #1 chk(w, e, rdata);
  endtask
  task automatic strb(input logic [7:0] e);
    logic [7:0] n;
    n = 8'h00;
    u_core.fetch();
    repeat (4) begin
      #1 n = n + {7'h00, stb};
      @(posedge core_clk_i);
    end
    chk("strobe", e, n);
  endtask
  task automatic mvc(input logic [15:0] a, input logic [7:0] d,
                     input logic [7:0] e);
    u_core.move(a, d);
    #1 chk("cmd", e, {5'h00, cmd.prog, cmd.erase, err});
  endtask
  task automatic finish_test();
    $display("checks %0d fails %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  always @(posedge core_clk_i) begin
    cyc++;
    if (cyc == 2000) begin
      n_fail++;
      finish_test();
    end
  end
  initial begin
    repeat (16) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    rd("ctl", PROGRAM_STORE_CONTROL_ADDR, 8'h00);
    rd("scale", FLASH_SCALE_REGISTER_ADDR, 8'h03);
    rd("oneshot", ONESHOT_PERIOD_ADDR, 8'h01);
    rd("unmapped", 8'h00, 8'h00);
    strb(8'h01);
    wr(PROGRAM_STORE_CONTROL_ADDR, 8'hfc);
    rd("ctl", PROGRAM_STORE_CONTROL_ADDR, 8'h00);
    wr(FLASH_SCALE_REGISTER_ADDR, 8'hff);
    rd("scale", FLASH_SCALE_REGISTER_ADDR, 8'h1f);
    for (int i = 0; i < 4; i++) begin
      wr(FLASH_SCALE_REGISTER_ADDR, 8'h00);
      wr(ONESHOT_PERIOD_ADDR, os_t[i]);
      wr(FLASH_SCALE_REGISTER_ADDR, sl_t[i]);
      strb(ln_t[i]);
    end
    wr(IRQ_ENABLE_ADDR, 8'h07);
    wr(PROGRAM_STORE_CONTROL_ADDR, 8'h01);
    mvc(16'h1234, 8'ha5, 8'h04);
    chk("paddr", 8'h34, cmd.addr[7:0]);
    chk("pdata", 8'ha5, cmd.data);
    @(posedge core_clk_i);
    #1 chk("irq", 8'h01, {7'h00, irq});
    rd("status", IRQ_STATUS_ADDR, 8'h01);
    wr(IRQ_CLEAR_ADDR, 8'h01);
    rd("status", IRQ_STATUS_ADDR, 8'h00);
    chk("irq", 8'h00, {7'h00, irq});
    wr(PROGRAM_STORE_CONTROL_ADDR, 8'h03);
    mvc(16'h4321, 8'h5a, 8'h02);
    chk("edata", 8'h00, cmd.data);
    chk("eaddr", 8'h43, cmd.addr[15:8]);
    for (int i = 0; i < 2; i++) begin
      @(posedge core_clk_i);
      mon <= i[0];
      src <= ~i[0];
      mvc(16'h0100, 8'h11, 8'h01);
    end
    @(posedge core_clk_i);
    mon <= 1'b1;
    src <= 1'b1;
    wr(IRQ_ENABLE_ADDR, 8'h00);
    rd("status", IRQ_STATUS_ADDR, 8'h06);
    chk("masked", 8'h00, {7'h00, irq});
    wr(IRQ_CLEAR_ADDR, 8'h07);
    wr(IRQ_STATUS_ADDR, 8'hff);
    rd("status", IRQ_STATUS_ADDR, 8'h00);
    wr(PROGRAM_STORE_CONTROL_ADDR, 8'h00);
    mvc(16'h0200, 8'h22, 8'h00);
    finish_test();
  end
endmodule
`default_nettype wire
